// *** rtl/dcpwm_top.sv ***
// Dual channel pwm timer: register bank, counters, interrupts and pin muxing
`timescale 1ns/1ps
`default_nettype none
`include "dcpwm_regs.svh"

// What this block does
// - Tick from 8-bit prescaler then 1..16 divide
// - Sixteen-bit period and compare values
// - One-shot or free-running with buffered updates
// - Selectable inversion and 8-bit dead zone
// - Rate is clock over prescale+1, divide, period+1
// - Two identical independent channels
// - Pulses reach pins only as alternate function
// - Manual load makes writes the starting values
// - Compare writes accepted into buffer while running
// - Auto reload copies buffers at period end
// - Period interrupt ignores the compare value
// - Dead zone delays only rising edges
module dcpwm_top (
    input  wire logic                     clk_i,
    input  wire logic                     rst_n_i,
    input  wire dcpwm_pkg::dcpwm_bus_type bus_i,
    output logic [15:0]                   rdata_o,
    output logic                          irq_o,
    input  wire logic [1:0]               alt_sel_i,
    input  wire logic [1:0]               gpio_out_i,
    input  wire logic [1:0]               gpio_oe_i,
    output logic                          pulse_pin_a_o,
    output logic                          pulse_pin_a_oe_o,
    output logic                          pulse_pin_b_o,
    output logic                          pulse_pin_b_oe_o
);

    dcpwm_pkg::dcpwm_state_type st_r;
    dcpwm_pkg::dcpwm_state_type st_nxt;
    logic [1:0]                 tick;
    logic [1:0]                 ev;
    logic [1:0]                 pulse_out;
    logic [1:0]                 wr_per;
    logic [1:0]                 wr_cmp;

    function automatic logic dcpwm_hit(input logic [7:0] addr, input logic [7:0] off);
        dcpwm_hit = addr == off;
    endfunction : dcpwm_hit

    assign wr_per[0] = bus_i.wr && dcpwm_hit(bus_i.addr, `DCPWM_OFF_PER0);
    assign wr_per[1] = bus_i.wr && dcpwm_hit(bus_i.addr, `DCPWM_OFF_PER1);
    assign wr_cmp[0] = bus_i.wr && dcpwm_hit(bus_i.addr, `DCPWM_OFF_CMP0);
    assign wr_cmp[1] = bus_i.wr && dcpwm_hit(bus_i.addr, `DCPWM_OFF_CMP1);

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_chan
            dcpwm_prescale u_pre (
                .clk_i    (clk_i),
                .rst_n_i  (rst_n_i),
                .en_i     (st_r.ch[gi].running),
                .presc_i  (st_r.presc[gi]),
                .divsel_i (st_r.divsel[gi]),
                .tick_o   (tick[gi])
            );

            // Period end ignores compare, so the channel doubles as a plain timer
            assign ev[gi] = st_r.ch[gi].running && tick[gi]
                            && st_r.ch[gi].cnt == `DCPWM_RST_16;

            dcpwm_deadzone u_dz (
                .clk_i    (clk_i),
                .rst_n_i  (rst_n_i),
                .raw_i    (st_r.ch[gi].level),
                .delay_i  (st_r.dz[gi]),
                .invert_i (st_r.ctrl[gi].inv),
                .pulse_o  (pulse_out[gi])
            );
        end
    endgenerate

    always_comb begin
        st_nxt = st_r;
        st_nxt.rdata = `DCPWM_RST_16;

        if (bus_i.wr) begin
            case (bus_i.addr)
                `DCPWM_OFF_CTRL: begin
                    for (int i = 0; i < 2; i++) begin
                        st_nxt.ctrl[i] = bus_i.wdata[i*`DCPWM_CTRL_STRIDE +: 4];
                    end
                end
                `DCPWM_OFF_PRESCALE: begin
                    for (int i = 0; i < 2; i++) begin
                        st_nxt.presc[i] = bus_i.wdata[i*`DCPWM_BYTE_STRIDE +: 8];
                    end
                end
                `DCPWM_OFF_DIVSEL: begin
                    for (int i = 0; i < 2; i++) begin
                        st_nxt.divsel[i] = bus_i.wdata[i*`DCPWM_DIV_STRIDE +: 3];
                    end
                end
                `DCPWM_OFF_DEADZONE: begin
                    for (int i = 0; i < 2; i++) begin
                        st_nxt.dz[i] = bus_i.wdata[i*`DCPWM_BYTE_STRIDE +: 8];
                    end
                end
                `DCPWM_OFF_INT_EN: st_nxt.ien = bus_i.wdata[1:0];
                default: ;
            endcase
        end

        for (int i = 0; i < 2; i++) begin
            // Buffers always take the write; the active set changes only as below
            if (wr_per[i]) begin
                st_nxt.per_buf[i] = bus_i.wdata;
            end
            if (wr_cmp[i]) begin
                st_nxt.cmp_buf[i] = bus_i.wdata;
            end
            if (st_r.ctrl[i].mload && wr_per[i]) begin
                st_nxt.ch[i].act_period = bus_i.wdata;
            end
            if (st_r.ctrl[i].mload && wr_cmp[i]) begin
                st_nxt.ch[i].act_cmp = bus_i.wdata;
            end

            st_nxt.ch[i].run_q = st_r.ctrl[i].run;
            if (!st_r.ctrl[i].run) begin
                st_nxt.ch[i].running = 1'b0;
                st_nxt.ch[i].level = 1'b0;
            end else if (!st_r.ch[i].run_q) begin
                st_nxt.ch[i].running = 1'b1;
                st_nxt.ch[i].cnt = st_r.ch[i].act_period;
                st_nxt.ch[i].level = 1'b0;
            end else if (ev[i]) begin
                st_nxt.ch[i].level = 1'b0;
                if (st_r.ctrl[i].auto_reload) begin
                    st_nxt.ch[i].act_period = st_r.per_buf[i];
                    st_nxt.ch[i].act_cmp = st_r.cmp_buf[i];
                    st_nxt.ch[i].cnt = st_r.per_buf[i];
                end else begin
                    st_nxt.ch[i].running = 1'b0;
                    st_nxt.ch[i].cnt = st_r.ch[i].act_period;
                end
            end else if (st_r.ch[i].running && tick[i]) begin
                st_nxt.ch[i].cnt = st_r.ch[i].cnt - 16'h0001;
                if (st_r.ch[i].cnt == st_r.ch[i].act_cmp) begin
                    st_nxt.ch[i].level = 1'b1;
                end
            end
        end

        // A new event wins over a clear in the same cycle
        if (bus_i.wr && dcpwm_hit(bus_i.addr, `DCPWM_OFF_INT_CLR)) begin
            st_nxt.sts = st_r.sts & ~bus_i.wdata[1:0];
        end
        st_nxt.sts = st_nxt.sts | ev;

        if (bus_i.rd) begin
            case (bus_i.addr)
                `DCPWM_OFF_CTRL: begin
                    st_nxt.rdata = {4'h0, st_r.ctrl[1], 4'h0, st_r.ctrl[0]};
                end
                `DCPWM_OFF_PRESCALE: st_nxt.rdata = {st_r.presc[1], st_r.presc[0]};
                `DCPWM_OFF_DIVSEL: begin
                    st_nxt.rdata = {5'h00, st_r.divsel[1], 5'h00, st_r.divsel[0]};
                end
                `DCPWM_OFF_DEADZONE: st_nxt.rdata = {st_r.dz[1], st_r.dz[0]};
                `DCPWM_OFF_PER0:     st_nxt.rdata = st_r.per_buf[0];
                `DCPWM_OFF_CMP0:     st_nxt.rdata = st_r.cmp_buf[0];
                `DCPWM_OFF_PER1:     st_nxt.rdata = st_r.per_buf[1];
                `DCPWM_OFF_CMP1:     st_nxt.rdata = st_r.cmp_buf[1];
                `DCPWM_OFF_INT_STS:  st_nxt.rdata = {14'h0000, st_r.sts};
                `DCPWM_OFF_INT_EN:   st_nxt.rdata = {14'h0000, st_r.ien};
                `DCPWM_OFF_CNT0:     st_nxt.rdata = st_r.ch[0].cnt;
                `DCPWM_OFF_CNT1:     st_nxt.rdata = st_r.ch[1].cnt;
                default:             st_nxt.rdata = `DCPWM_RST_16;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rdata_o = st_r.rdata;
    assign irq_o = |(st_r.sts & st_r.ien);

    // Without the alternate function the pin stays an ordinary gpio
    assign pulse_pin_a_o    = alt_sel_i[0] ? pulse_out[0] : gpio_out_i[0];
    assign pulse_pin_a_oe_o = alt_sel_i[0] ? 1'b1 : gpio_oe_i[0];
    assign pulse_pin_b_o    = alt_sel_i[1] ? pulse_out[1] : gpio_out_i[1];
    assign pulse_pin_b_oe_o = alt_sel_i[1] ? 1'b1 : gpio_oe_i[1];

    a_period_end_flag: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ev[0] |=> st_r.sts[0] ##0 (st_r.ien[0] -> irq_o))
        else $error("period end did not flag an interrupt");

    a_reload_applies: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ev[0] && st_r.ctrl[0].auto_reload && st_r.ch[0].run_q && st_r.ctrl[0].run
        |=> st_r.ch[0].act_period == $past(st_r.per_buf[0])
            && st_r.ch[0].act_cmp == $past(st_r.cmp_buf[0]) && st_r.ch[0].running)
        else $error("buffered values not applied at period end");

    a_oneshot_stops: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ev[0] && !st_r.ctrl[0].auto_reload |=> !st_r.ch[0].running [*2])
        else $error("one-shot channel kept running");

    a_run_clear_halts: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !st_r.ctrl[0].run |=> !st_r.ch[0].running && !st_r.ch[0].level)
        else $error("clearing run did not halt the channel");

    a_manual_load: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        wr_per[0] && st_r.ctrl[0].mload && !ev[0]
        |=> st_r.ch[0].act_period == $past(bus_i.wdata))
        else $error("manual load did not set the active period");

    a_cmp_buffered: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        wr_cmp[0] && !st_r.ctrl[0].mload && !ev[0]
        |=> st_r.cmp_buf[0] == $past(bus_i.wdata) && $stable(st_r.ch[0].act_cmp))
        else $error("compare write reached the active value directly");

    a_match_goes_high: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        st_r.ch[0].running && st_r.ch[0].run_q && st_r.ctrl[0].run && tick[0]
        && st_r.ch[0].cnt != 16'h0000 && st_r.ch[0].cnt == st_r.ch[0].act_cmp
        |=> st_r.ch[0].level)
        else $error("compare match did not raise the output");

    a_end_goes_low: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ev[0] |=> !st_r.ch[0].level)
        else $error("period end did not return the output low");

    a_count_steps: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        st_r.ch[0].running && st_r.ch[0].run_q && st_r.ctrl[0].run && tick[0]
        && st_r.ch[0].cnt != 16'h0000 |=> st_r.ch[0].cnt == $past(st_r.ch[0].cnt) - 16'h0001)
        else $error("counter did not step down by one on a tick");

    a_start_loads: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $rose(st_r.ctrl[0].run) |=> st_r.ch[0].running
            && st_r.ch[0].cnt == $past(st_r.ch[0].act_period, 1))
        else $error("start did not load the active period");

endmodule : dcpwm_top
`default_nettype wire

// *** rtl/dcpwm_regs.svh ***
// Register offsets, field positions, reset values and limits of the dual pwm timer
`ifndef DCPWM_REGS_SVH
`define DCPWM_REGS_SVH

`define DCPWM_OFF_CTRL      8'h00
`define DCPWM_OFF_PRESCALE  8'h04
`define DCPWM_OFF_DIVSEL    8'h08
`define DCPWM_OFF_DEADZONE  8'h0C
`define DCPWM_OFF_PER0      8'h10
`define DCPWM_OFF_CMP0      8'h14
`define DCPWM_OFF_PER1      8'h18
`define DCPWM_OFF_CMP1      8'h1C
`define DCPWM_OFF_INT_STS   8'h20
`define DCPWM_OFF_INT_CLR   8'h24
`define DCPWM_OFF_INT_EN    8'h28
`define DCPWM_OFF_CNT0      8'h2C
`define DCPWM_OFF_CNT1      8'h30

`define DCPWM_CTRL_RUN      0
`define DCPWM_CTRL_MLOAD    1
`define DCPWM_CTRL_AUTO     2
`define DCPWM_CTRL_INV      3
`define DCPWM_CTRL_STRIDE   8

`define DCPWM_BYTE_STRIDE   8
`define DCPWM_DIV_STRIDE    8
`define DCPWM_DIV_MAX_SEL   3'h4

`define DCPWM_RST_16        16'h0000
`define DCPWM_RST_8         8'h00
`define DCPWM_RST_DIV       3'h0
`define DCPWM_RST_CTRL      4'h0

`endif

// *** rtl/dcpwm_pkg.sv ***
// Types shared by the dual pwm timer
`default_nettype none
package dcpwm_pkg;

    typedef struct packed {
        logic [7:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } dcpwm_bus_type;

    typedef struct packed {
        logic        inv;
        logic        auto_reload;
        logic        mload;
        logic        run;
    } dcpwm_ctrl_type;

    typedef struct packed {
        logic        run_q;
        logic        running;
        logic        level;
        logic [15:0] cnt;
        logic [15:0] act_period;
        logic [15:0] act_cmp;
    } dcpwm_chan_type;

    typedef struct packed {
        dcpwm_ctrl_type [1:0]       ctrl;
        logic [1:0][7:0]            presc;
        logic [1:0][2:0]            divsel;
        logic [1:0][7:0]            dz;
        logic [1:0][15:0]           per_buf;
        logic [1:0][15:0]           cmp_buf;
        logic [1:0]                 sts;
        logic [1:0]                 ien;
        dcpwm_chan_type [1:0]       ch;
        logic [15:0]                rdata;
    } dcpwm_state_type;

    typedef struct packed {
        logic [7:0]  pcnt;
        logic [3:0]  dcnt;
    } dcpwm_pre_state_type;

    typedef struct packed {
        logic [7:0]  cnt;
        logic        lvl;
        logic        out;
    } dcpwm_dz_state_type;

endpackage : dcpwm_pkg
`default_nettype wire

// *** rtl/dcpwm_prescale.sv ***
// Prescaler and power-of-two divider that make one channel's counting tick
`timescale 1ns/1ps
`default_nettype none
`include "dcpwm_regs.svh"

module dcpwm_prescale (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       en_i,
    input  wire logic [7:0] presc_i,
    input  wire logic [2:0] divsel_i,
    output logic            tick_o
);

    dcpwm_pkg::dcpwm_pre_state_type st_r;
    dcpwm_pkg::dcpwm_pre_state_type st_nxt;
    logic [3:0]                     div_lim;

    // Codes above the largest divide fall back to divide by 16
    always_comb begin
        case (divsel_i)
            3'h0:    div_lim = 4'h0;
            3'h1:    div_lim = 4'h1;
            3'h2:    div_lim = 4'h3;
            3'h3:    div_lim = 4'h7;
            default: div_lim = 4'hF;
        endcase
    end

    assign tick_o = en_i && st_r.pcnt == 8'h00 && st_r.dcnt == 4'h0;

    // Held at reload while idle so the first period starts full length
    always_comb begin
        st_nxt = st_r;
        if (!en_i) begin
            st_nxt.pcnt = presc_i;
            st_nxt.dcnt = div_lim;
        end else if (st_r.pcnt == 8'h00) begin
            st_nxt.pcnt = presc_i;
            st_nxt.dcnt = (st_r.dcnt == 4'h0) ? div_lim : st_r.dcnt - 4'h1;
        end else begin
            st_nxt.pcnt = st_r.pcnt - 8'h01;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

endmodule : dcpwm_prescale
`default_nettype wire

// *** rtl/dcpwm_deadzone.sv ***
// Rising-edge dead-zone delay and polarity inverter for one pulse output
`timescale 1ns/1ps
`default_nettype none

module dcpwm_deadzone (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       raw_i,
    input  wire logic [7:0] delay_i,
    input  wire logic       invert_i,
    output logic            pulse_o
);

    dcpwm_pkg::dcpwm_dz_state_type st_r;
    dcpwm_pkg::dcpwm_dz_state_type st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (!raw_i) begin
            st_nxt.lvl = 1'b0;
            st_nxt.cnt = delay_i;
        end else if (st_r.cnt == 8'h00) begin
            st_nxt.lvl = 1'b1;
        end else begin
            st_nxt.cnt = st_r.cnt - 8'h01;
        end
        st_nxt.out = st_nxt.lvl ^ invert_i;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign pulse_o = st_r.out;

    a_fall_is_immediate: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !raw_i |=> !st_r.lvl) else $error("dead zone delayed a falling edge");

    a_rise_is_delayed: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $rose(raw_i) && delay_i == 8'h03 && st_r.cnt == 8'h03 ##1 raw_i [*3]
        |-> !st_r.lvl ##1 (raw_i -> st_r.lvl))
        else $error("dead zone rise not delayed by its count");

endmodule : dcpwm_deadzone
`default_nettype wire

// *** tb/dcpwm_load.sv ***
// Pulse load on one pin: resolves the pad level and times its edges
`timescale 1ns/1ps
`default_nettype none
module dcpwm_load (
    input  wire logic   clk_i,
    input  wire logic   val_i,
    input  wire logic   oe_i,
    output logic [15:0] period_o,
    output logic [15:0] high_o,
    output logic [15:0] rises_o
);
    logic        pad;
    logic        pad_q      = 1'b0;
    logic [15:0] since_rise = 16'h0000;
    logic [15:0] high_cnt   = 16'h0000;

    initial begin
        period_o = 16'h0000;
        high_o   = 16'h0000;
        rises_o  = 16'h0000;
    end

    // The pad has a pull-down, so a released pin reads low rather than its last value
    assign pad = oe_i ? val_i : 1'b0;

    always @(posedge clk_i) begin
        pad_q      <= pad;
        since_rise <= since_rise + 16'h0001;
        if (pad) begin
            high_cnt <= high_cnt + 16'h0001;
        end
        if (pad && !pad_q) begin
            period_o   <= since_rise;
            since_rise <= 16'h0001;
            high_cnt   <= 16'h0001;
            rises_o    <= rises_o + 16'h0001;
        end
        if (!pad && pad_q) begin
            high_o <= high_cnt;
        end
    end
endmodule : dcpwm_load
`default_nettype wire

// *** tb/dual_channel_pwm_timer_tb_top.sv ***
// Self-checking bench for the dual channel pulse timer
`timescale 1ns/1ps
`default_nettype none
`include "dcpwm_regs.svh"
module dual_channel_pwm_timer_tb_top;
    logic                     clk_i    = 1'b0;
    logic                     rst_n_i  = 1'b0;
    dcpwm_pkg::dcpwm_bus_type bus      = '0;
    logic [15:0]              rdata;
    logic                     irq;
    logic [1:0]               alt_sel  = 2'h3;
    logic [1:0]               gpio_out = 2'h0;
    logic [1:0]               gpio_oe  = 2'h0;
    logic [1:0]               pin;
    logic [1:0]               oe;
    logic [15:0]              per [2];
    logic [15:0]              hi [2];
    logic [15:0]              rises [2];
    int                       failures = 0;
    int                       total_checks = 0;

    always #25 clk_i = ~clk_i;

    dcpwm_top i_dcpwm_top (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .bus_i(bus), .rdata_o(rdata), .irq_o(irq),
        .alt_sel_i(alt_sel), .gpio_out_i(gpio_out), .gpio_oe_i(gpio_oe),
        .pulse_pin_a_o(pin[0]), .pulse_pin_a_oe_o(oe[0]),
        .pulse_pin_b_o(pin[1]), .pulse_pin_b_oe_o(oe[1]));
    dcpwm_load i_dcpwm_load_a (.clk_i(clk_i), .val_i(pin[0]), .oe_i(oe[0]),
        .period_o(per[0]), .high_o(hi[0]), .rises_o(rises[0]));
    dcpwm_load i_dcpwm_load_b (.clk_i(clk_i), .val_i(pin[1]), .oe_i(oe[1]),
        .period_o(per[1]), .high_o(hi[1]), .rises_o(rises[1]));

    task automatic report_and_stop;
        $display("Checks %0d, mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_i);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_i);
        bus.wr <= 1'b0;
        #1;
    endtask : wr

    // Read data stand only in the cycle after the strobe, so sample just past that edge
    task automatic rdchk(input logic [7:0] a, input logic [15:0] exp, input string what);
        @(posedge clk_i);
        bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk_i);
        bus.rd <= 1'b0;
        #1;
        check(what, rdata, exp);
    endtask : rdchk

    task automatic wait_rises(input int ch, input int n);
        logic [15:0] start;
        int          i;
        start = rises[ch];
        // Look just past the edge so the load's counters have settled
        for (i = 0; i < 2000 && 16'(rises[ch] - start) < n; i++) begin
            @(posedge clk_i);
            #1;
        end
        if (i == 2000) begin
            check("pulse timeout", 16'h0001, 16'h0000);
            report_and_stop();
        end
    endtask : wait_rises

    // Manual load first so the written values become the active ones, then run
    task automatic setup(input int ch, input logic [7:0] pre, input logic [2:0] dv,
                         input logic [15:0] p, input logic [15:0] c, input logic [7:0] dz,
                         input logic [3:0] fl);
        int sh;
        sh = ch * 8;
        wr(`DCPWM_OFF_CTRL, 16'h0002 << sh);
        wr(`DCPWM_OFF_PRESCALE, 16'(pre) << sh);
        wr(`DCPWM_OFF_DIVSEL, 16'(dv) << sh);
        wr(`DCPWM_OFF_DEADZONE, 16'(dz) << sh);
        wr(8'(`DCPWM_OFF_PER0 + 8 * ch), p);
        wr(8'(`DCPWM_OFF_CMP0 + 8 * ch), c);
        wr(`DCPWM_OFF_CTRL, 16'h0000);
        wr(`DCPWM_OFF_CTRL, 16'(fl) << sh);
    endtask : setup

    task automatic measure(input int ch, input logic [15:0] ep, input logic [15:0] eh);
        wait_rises(ch, 3);
        check("period", per[ch], ep);
        check("high time", hi[ch], eh);
    endtask : measure

    task automatic sc_regs;
        check("irq", 16'(irq), 16'h0000);
        check("pin enables", 16'(oe), 16'h0003);
        rdchk(`DCPWM_OFF_CTRL, 16'h0000, "ctrl reset");
        rdchk(`DCPWM_OFF_PER0, 16'h0000, "per0 reset");
        wr(`DCPWM_OFF_PER1, 16'hFFFF);
        rdchk(`DCPWM_OFF_PER1, 16'hFFFF, "per1 full width");
        rdchk(`DCPWM_OFF_INT_STS, 16'h0000, "status reset");
        wr(`DCPWM_OFF_PRESCALE, 16'hA55A);
        rdchk(`DCPWM_OFF_PRESCALE, 16'hA55A, "prescale");
        wr(`DCPWM_OFF_INT_STS, 16'h0003);
        rdchk(`DCPWM_OFF_INT_STS, 16'h0000, "status read-only");
        rdchk(`DCPWM_OFF_INT_CLR, 16'h0000, "clear write-only");
        rdchk(8'h3C, 16'h0000, "unmapped");
    endtask : sc_regs

    task automatic sc_divide;
        // Code 5 is past the largest divide and must behave as divide by 16
        for (int d = 0; d < 6; d++) begin
            setup(0, 8'h01, 3'(d), 16'h0003, 16'h0002, 8'h00, 4'h5);
            measure(0, 16'(8 << (d > `DCPWM_DIV_MAX_SEL ? 4 : d)),
                    16'(4 << (d > `DCPWM_DIV_MAX_SEL ? 4 : d)));
        end
    endtask : sc_divide

    task automatic sc_update_halt;
        logic [15:0] r;
        setup(0, 8'h00, 3'h0, 16'h0004, 16'h0002, 8'h00, 4'h5);
        measure(0, 16'h0005, 16'h0002);
        wr(`DCPWM_OFF_CMP0, 16'h0003);
        wr(`DCPWM_OFF_PER0, 16'h0007);
        measure(0, 16'h0008, 16'h0003);
        wr(`DCPWM_OFF_CTRL, 16'h0000);
        repeat (10) @(posedge clk_i);
        r = rises[0];
        repeat (50) @(posedge clk_i);
        check("rises after halt", rises[0], r);
        check("pin after halt", 16'(pin[0]), 16'h0000);
    endtask : sc_update_halt

    task automatic sc_second_channel;
        setup(1, 8'h00, 3'h0, 16'h0009, 16'h0006, 8'h03, 4'h5);
        measure(1, 16'h000A, 16'h0003);
        setup(1, 8'h00, 3'h0, 16'h0009, 16'h0006, 8'h00, 4'hD);
        measure(1, 16'h000A, 16'h0004);
        wr(`DCPWM_OFF_CTRL, 16'h0800);
        repeat (4) @(posedge clk_i);
        #1;
        check("inverted idle", 16'(pin[1]), 16'h0001);
    endtask : sc_second_channel

    task automatic sc_oneshot_irq;
        logic [15:0] r;
        int          i;
        wr(`DCPWM_OFF_INT_CLR, 16'h0003);
        wr(`DCPWM_OFF_INT_EN, 16'h0001);
        r = rises[0];
        setup(0, 8'h00, 3'h0, 16'h0005, 16'h0000, 8'h00, 4'h1);
        for (i = 0; i < 200 && irq !== 1'b1; i++) @(posedge clk_i);
        check("irq raised", 16'(irq), 16'h0001);
        if (irq !== 1'b1) begin
            report_and_stop();
        end
        check("no pulse", rises[0], r);
        repeat (20) @(posedge clk_i);
        rdchk(`DCPWM_OFF_CNT0, 16'h0005, "stopped count");
        rdchk(`DCPWM_OFF_INT_STS, 16'h0001, "status set");
        wr(`DCPWM_OFF_INT_EN, 16'h0000);
        check("irq masked", 16'(irq), 16'h0000);
        wr(`DCPWM_OFF_INT_EN, 16'h0001);
        check("irq unmasked", 16'(irq), 16'h0001);
        wr(`DCPWM_OFF_INT_CLR, 16'h0001);
        check("irq cleared", 16'(irq), 16'h0000);
        rdchk(`DCPWM_OFF_INT_STS, 16'h0000, "status cleared");
    endtask : sc_oneshot_irq

    task automatic sc_gpio;
        @(posedge clk_i);
        alt_sel  <= 2'h0;
        gpio_out <= 2'h1;
        gpio_oe  <= 2'h1;
        repeat (3) @(posedge clk_i);
        #1;
        check("gpio enables", 16'(oe), 16'h0001);
        check("gpio level", 16'(pin[0]), 16'h0001);
    endtask : sc_gpio

    initial begin
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        #1;
        sc_regs();
        sc_divide();
        sc_update_halt();
        sc_second_channel();
        sc_oneshot_irq();
        sc_gpio();
        report_and_stop();
    end
endmodule : dual_channel_pwm_timer_tb_top
`default_nettype wire
